// *** rtl/rwwt_pkg.sv ***
// constants for the runaway watchdog and warm-up timer
`default_nettype none
package rwwt_pkg;
  localparam int unsigned AW     = 12;
  localparam int unsigned DW     = 32;
  // register indices; byte address is four times the index
  localparam logic [9:0]  IDX_MODE  = 10'h05c;
  localparam logic [9:0]  IDX_CMD   = 10'h05d;
  localparam logic [9:0]  IDX_T16   = 10'h05e;
  localparam logic [9:0]  IDX_STAT  = 10'h060;
  localparam logic [9:0]  IDX_CLR   = 10'h061;
  localparam logic [9:0]  IDX_EN    = 10'h062;
  localparam logic [9:0]  IDX_CNT   = 10'h063;
  // command codes
  localparam logic [7:0]  CODE_CLR  = 8'h4e;
  localparam logic [7:0]  CODE_DIS  = 8'hb1;
  // mode and quick warm-up register fields
  localparam int unsigned B_ON      = 7;
  localparam int unsigned B_SEL     = 5;
  localparam int unsigned B_WARM    = 4;
  localparam int unsigned B_RLINK   = 1;
  localparam int unsigned B_QCU     = 0;
  // values after reset
  localparam logic        RST_ON    = 1'b1;
  localparam logic [1:0]  RST_SEL   = 2'h0;
  localparam logic        RST_WARM  = 1'b0;
  localparam logic        RST_RLINK = 1'b0;
  localparam logic        RST_QCU   = 1'b0;
  // counter chain
  localparam int unsigned PRE_W     = 7;
  localparam int unsigned MAIN_W    = 15;
  localparam int unsigned CNT_W     = PRE_W + MAIN_W;
  localparam int unsigned WD_EXP0   = 15;
  localparam int unsigned WD_EXP1   = 17;
  localparam int unsigned WD_EXP2   = 19;
  localparam int unsigned WD_EXP3   = 21;
  localparam int unsigned WARM_Q    = 7;
  localparam int unsigned WARM_S    = PRE_W + 7;
  localparam int unsigned WARM_L    = PRE_W + 9;
  // interrupt status bits
  localparam int unsigned IRQ_W     = 2;
  localparam int unsigned I_NMI     = 0;
  localparam int unsigned I_WARM    = 1;
  typedef enum logic [1:0] {
    RWWT_IDLE = 2'h0,
    RWWT_WARM = 2'h1,
    RWWT_DONE = 2'h3
  } rwwt_state_t;
endpackage
`default_nettype wire

// *** rtl/rwwt_top.sv ***
// runaway watchdog with shared oscillator warm-up timer, APB slave
// Function
// - a detected runaway raises the non-maskable runaway interrupt
// - counter is a 7-stage then a 15-stage binary counter on the system clock
// - period select picks overflow tap 2^15/17/19/21; overflow interrupts and drives out
// - period select resets to 00, the shortest period
// - command 4eh clears the counter, which then keeps counting
// - watchdog-on bit resets to 1, watchdog enabled
// - disable needs watchdog-on cleared first, then command b1h; either alone ignored
// - setting watchdog-on re-enables without any command
// - reset-link bit routes watchdog-out to chip reset; resets to 0
// - linked overflow also resets the watchdog itself
// - same chain times oscillator warm-up after stop release or clock change
// - warm-up select picks the 2^7 or 2^9 output of the 15-stage counter
// - quick warm-up bit selects a 2^7 count for stable external oscillators
// - quick warm-up is not available while the watchdog runs
// - watchdog counts as soon as reset is released
// - counter frozen in deep idle and stop, runs in run and light idle
//
// The implementer's own choice: the APB slave port.
`default_nettype none
module rwwt_top (
  // clock, reset, enable
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        ce,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [rwwt_pkg::AW-1:0]     paddr,
  input  wire logic [rwwt_pkg::DW-1:0]     pwdata,
  output var  logic [rwwt_pkg::DW-1:0]     prdata,
  output var  logic                        pready,
  output var  logic                        pslverr,
  // power state
  input  wire logic                        deep_idle_mode,
  input  wire logic                        stop_mode,
  input  wire logic                        warmup_start,
  // events
  output var  logic                        runaway_interrupt,
  output var  logic                        watchdog_out,
  output var  logic                        chip_reset_req,
  output var  logic                        warmup_busy,
  output var  logic                        warmup_done,
  output var  logic                        irq
);
  logic [rwwt_pkg::PRE_W-1:0]  pre7_r;
  logic [rwwt_pkg::MAIN_W-1:0] main15_r;
  logic [rwwt_pkg::CNT_W-1:0]  cnt;
  logic [rwwt_pkg::CNT_W-1:0]  wd_mask;
  logic [rwwt_pkg::CNT_W-1:0]  wm_mask;
  logic                        on_r;
  logic [1:0]                  sel_r;
  logic                        warm_r;
  logic                        rlink_r;
  logic                        qcu_r;
  logic                        wd_en_r;
  logic [rwwt_pkg::IRQ_W-1:0]  stat_r;
  logic [rwwt_pkg::IRQ_W-1:0]  irq_en_r;
  rwwt_pkg::rwwt_state_t       state_r;
  rwwt_pkg::rwwt_state_t       state_nxt;
  logic [9:0]                  idx;
  logic                        acc;
  logic                        commit;
  logic                        wr_mode;
  logic                        wr_cmd;
  logic                        wr_t16;
  logic                        wr_clr;
  logic                        wr_en;
  logic                        warming;
  logic                        adv;
  logic                        pre_carry;
  logic                        ovf_ev;
  logic                        self_rst;
  logic                        quick;
  logic                        warm_hit;
  logic                        clr_cnt;
  logic                        mapped;
  logic [rwwt_pkg::DW-1:0]     rd_val;

  assign idx     = paddr[rwwt_pkg::AW-1:2];
  assign acc     = ce & psel & penable & ~pready;
  assign commit  = ce & psel & penable & pready & pwrite;
  assign wr_mode = commit & (idx == rwwt_pkg::IDX_MODE);
  assign wr_cmd  = commit & (idx == rwwt_pkg::IDX_CMD);
  assign wr_t16  = commit & (idx == rwwt_pkg::IDX_T16);
  assign wr_clr  = commit & (idx == rwwt_pkg::IDX_CLR);
  assign wr_en   = commit & (idx == rwwt_pkg::IDX_EN);
  assign cnt     = {main15_r, pre7_r};
  assign warming = (state_r == rwwt_pkg::RWWT_WARM);

  // counter stands still in deep idle and stop
  assign adv = ce & ~deep_idle_mode & ~stop_mode & (wd_en_r | warming);
  assign pre_carry = &pre7_r;

  // overflow tap mask from the period select
  always_comb begin
    case (sel_r)
      2'h0:    wd_mask = 22'((23'h1 << rwwt_pkg::WD_EXP0) - 23'h1);
      2'h1:    wd_mask = 22'((23'h1 << rwwt_pkg::WD_EXP1) - 23'h1);
      2'h2:    wd_mask = 22'((23'h1 << rwwt_pkg::WD_EXP2) - 23'h1);
      default: wd_mask = 22'((23'h1 << rwwt_pkg::WD_EXP3) - 23'h1);
    endcase
  end
  assign ovf_ev   = adv & wd_en_r & ~warming & ((cnt & wd_mask) == wd_mask);
  assign self_rst = ovf_ev & rlink_r;

  // quick warm-up only while the watchdog is stopped
  assign quick = qcu_r & ~wd_en_r;
  always_comb begin
    if (quick) begin
      wm_mask = 22'((23'h1 << rwwt_pkg::WARM_Q) - 23'h1);
    end else if (warm_r) begin
      wm_mask = 22'((23'h1 << rwwt_pkg::WARM_L) - 23'h1);
    end else begin
      wm_mask = 22'((23'h1 << rwwt_pkg::WARM_S) - 23'h1);
    end
  end
  assign warm_hit = adv & warming & ((cnt & wm_mask) == wm_mask);

  assign clr_cnt = (wr_cmd & (pwdata[7:0] == rwwt_pkg::CODE_CLR))
                 | (ce & warmup_start) | self_rst;

  // two chained binary counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre7_r   <= '0;
      main15_r <= '0;
    end else if (clr_cnt) begin
      pre7_r   <= '0;
      main15_r <= '0;
    end else if (adv) begin
      pre7_r <= pre7_r + 7'h1;
      if (pre_carry) begin
        main15_r <= main15_r + 15'h1;
      end
    end
  end

  // mode and quick warm-up registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_r    <= rwwt_pkg::RST_ON;
      sel_r   <= rwwt_pkg::RST_SEL;
      warm_r  <= rwwt_pkg::RST_WARM;
      rlink_r <= rwwt_pkg::RST_RLINK;
      qcu_r   <= rwwt_pkg::RST_QCU;
    end else if (self_rst) begin
      on_r    <= rwwt_pkg::RST_ON;
      sel_r   <= rwwt_pkg::RST_SEL;
      warm_r  <= rwwt_pkg::RST_WARM;
      rlink_r <= rwwt_pkg::RST_RLINK;
      qcu_r   <= rwwt_pkg::RST_QCU;
    end else begin
      if (wr_mode) begin
        on_r    <= pwdata[rwwt_pkg::B_ON];
        sel_r   <= pwdata[rwwt_pkg::B_SEL+:2];
        warm_r  <= pwdata[rwwt_pkg::B_WARM];
        rlink_r <= pwdata[rwwt_pkg::B_RLINK];
      end
      if (wr_t16) begin
        qcu_r <= pwdata[rwwt_pkg::B_QCU];
      end
    end
  end

  // enable: guarded two-step disable, one-step enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_en_r <= rwwt_pkg::RST_ON;
    end else if (self_rst) begin
      wd_en_r <= rwwt_pkg::RST_ON;
    end else if (wr_mode && pwdata[rwwt_pkg::B_ON]) begin
      wd_en_r <= 1'b1;
    end else if (wr_cmd && pwdata[7:0] == rwwt_pkg::CODE_DIS && !on_r) begin
      wd_en_r <= 1'b0;
    end
  end

  // warm-up sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rwwt_pkg::RWWT_IDLE: begin
        if (ce && warmup_start) begin
          state_nxt = rwwt_pkg::RWWT_WARM;
        end
      end
      rwwt_pkg::RWWT_WARM: begin
        if (warm_hit) begin
          state_nxt = rwwt_pkg::RWWT_DONE;
        end
      end
      rwwt_pkg::RWWT_DONE: begin
        if (ce) begin
          state_nxt = rwwt_pkg::RWWT_IDLE;
        end
      end
      default: state_nxt = rwwt_pkg::RWWT_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= rwwt_pkg::RWWT_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warmup_busy <= 1'b0;
      warmup_done <= 1'b0;
    end else if (ce) begin
      warmup_busy <= (state_nxt == rwwt_pkg::RWWT_WARM);
      warmup_done <= warm_hit;
    end
  end

  // runaway outputs; watchdog_out holds until the clear code, a warm-up start or disable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      runaway_interrupt <= 1'b0;
      watchdog_out      <= 1'b0;
      chip_reset_req    <= 1'b0;
    end else if (ce) begin
      runaway_interrupt <= ovf_ev;
      chip_reset_req    <= self_rst;
      if (ovf_ev) begin
        watchdog_out <= 1'b1;
      end else if (clr_cnt || !wd_en_r) begin
        watchdog_out <= 1'b0;
      end
    end
  end

  // sticky status, set beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r   <= '0;
      irq_en_r <= '0;
      irq      <= 1'b0;
    end else if (ce) begin
      stat_r <= (stat_r & ~(wr_clr ? pwdata[rwwt_pkg::IRQ_W-1:0] : '0))
              | {warm_hit, ovf_ev};
      if (wr_en) begin
        irq_en_r <= pwdata[rwwt_pkg::IRQ_W-1:0];
      end
      irq <= |(stat_r & irq_en_r);
    end
  end

  // read mux
  always_comb begin
    rd_val = '0;
    mapped = 1'b1;
    case (idx)
      rwwt_pkg::IDX_MODE: begin
        rd_val[rwwt_pkg::B_ON]      = on_r;
        rd_val[rwwt_pkg::B_SEL+:2]  = sel_r;
        rd_val[rwwt_pkg::B_WARM]    = warm_r;
        rd_val[rwwt_pkg::B_RLINK]   = rlink_r;
      end
      rwwt_pkg::IDX_T16:  rd_val[rwwt_pkg::B_QCU] = qcu_r;
      rwwt_pkg::IDX_STAT: rd_val[rwwt_pkg::IRQ_W-1:0] = stat_r;
      rwwt_pkg::IDX_EN:   rd_val[rwwt_pkg::IRQ_W-1:0] = irq_en_r;
      rwwt_pkg::IDX_CNT:  rd_val[rwwt_pkg::CNT_W:0] = {wd_en_r, cnt};
      rwwt_pkg::IDX_CMD:  rd_val = '0;
      rwwt_pkg::IDX_CLR:  rd_val = '0;
      default:            mapped = 1'b0;
    endcase
  end

  // one wait state: ready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (ce) begin
      pready  <= acc;
      pslverr <= acc & ~mapped;
      if (acc && !pwrite) begin
        prdata <= rd_val;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cmd(logic [7:0] code);
    wr_cmd && pwdata[7:0] == code;
  endsequence
  sequence s_access;
    ce && psel && penable && !pready;
  endsequence

  a_apb_ready_answer: assert property (s_access |=> pready)
    else $error("apb access not answered in one cycle");
  a_nmi_on_ovf: assert property (
    ovf_ev |=> runaway_interrupt && watchdog_out)
    else $error("overflow without runaway interrupt");
  a_tap_lowest: assert property (
    ovf_ev |-> &cnt[14:0] && (sel_r == 2'h0 || &cnt[16:0]) && (sel_r < 2'h2 || &cnt[18:0])
    && (sel_r != 2'h3 || &cnt[20:0]))
    else $error("overflow at wrong tap");
  a_clear_code: assert property (
    s_cmd(rwwt_pkg::CODE_CLR) |=> cnt == '0)
    else $error("clear code did not zero counter");
  a_disable_pair: assert property (
    s_cmd(rwwt_pkg::CODE_DIS) && !on_r && !ovf_ev |=> !wd_en_r)
    else $error("disable sequence ignored");
  a_disable_guard: assert property (
    wd_en_r && on_r && !wr_mode |=> wd_en_r)
    else $error("watchdog disabled without clearing on bit");
  a_reenable_bit: assert property (
    wr_mode && pwdata[rwwt_pkg::B_ON] |=> wd_en_r)
    else $error("on bit did not re-enable");
  a_link_reset: assert property (
    ovf_ev && !rlink_r |=> !chip_reset_req)
    else $error("chip reset without reset link");
  a_self_reset: assert property (
    ovf_ev && rlink_r |=> chip_reset_req && cnt == '0 && sel_r == 2'h0 && !rlink_r)
    else $error("linked overflow did not reset watchdog");
  a_warm_start: assert property (
    ce && warmup_start && state_r == rwwt_pkg::RWWT_IDLE |=> warmup_busy && cnt == '0)
    else $error("warm-up did not start");
  a_quick_lock: assert property (wd_en_r |-> !quick)
    else $error("quick warm-up while watchdog runs");
  a_freeze_idle: assert property (
    (deep_idle_mode || stop_mode) && !commit && !warmup_start |=> $stable(cnt))
    else $error("counter moved in deep idle or stop");
  a_other_code: assert property (
    wr_cmd && pwdata[7:0] != rwwt_pkg::CODE_CLR && pwdata[7:0] != rwwt_pkg::CODE_DIS
    && !ovf_ev |=> $stable(wd_en_r))
    else $error("unknown command changed enable");
  // counting, enable freeze, status and warm-up
  a_count_step: assert property (
    adv && !clr_cnt |=> cnt == 22'($past(cnt) + 22'h1))
    else $error("counter did not advance by one");
  a_ce_freeze: assert property (
    !ce |=> $stable(cnt) && $stable(wd_en_r) && $stable(stat_r) && $stable(state_r))
    else $error("state moved while clock enable low");
  a_status_sticky: assert property (
    ovf_ev |=> stat_r[rwwt_pkg::I_NMI])
    else $error("overflow status not set");
  a_irq_level: assert property (
    ce |=> irq == |($past(stat_r & irq_en_r)))
    else $error("interrupt level wrong");
  a_out_hold: assert property (
    watchdog_out && wd_en_r && !clr_cnt |=> watchdog_out)
    else $error("watchdog out dropped early");
  a_apb_error: assert property (
    s_access && !mapped |=> pslverr)
    else $error("unmapped access without error");
  a_warm_done: assert property (
    warm_hit |=> warmup_done && !warmup_busy)
    else $error("warm-up end not flagged");
  a_warm_length: assert property (
    warm_hit |-> &cnt[6:0] && (quick || &cnt[13:0]) && (quick || !warm_r || &cnt[15:0]))
    else $error("warm-up ended at wrong count");
  a_quick_length: assert property (
    warming && quick && adv && &cnt[6:0] |-> warm_hit)
    else $error("quick warm-up did not end at its count");
  a_done_pulse: assert property (
    warmup_done && ce |=> !warmup_done)
    else $error("warm-up done longer than one cycle");
  a_link_pulse: assert property (
    chip_reset_req && ce |=> !chip_reset_req)
    else $error("chip reset request longer than one cycle");
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the runaway watchdog and warm-up timer
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_MODE = {rwwt_pkg::IDX_MODE, 2'b00};
  localparam logic [11:0] A_CMD  = {rwwt_pkg::IDX_CMD, 2'b00};
  localparam logic [11:0] A_QCK  = {rwwt_pkg::IDX_T16, 2'b00};
  localparam logic [11:0] A_STAT = {rwwt_pkg::IDX_STAT, 2'b00};
  localparam logic [11:0] A_CLR  = {rwwt_pkg::IDX_CLR, 2'b00};
  localparam logic [11:0] A_EN   = {rwwt_pkg::IDX_EN, 2'b00};
  localparam logic [11:0] A_CNT  = {rwwt_pkg::IDX_CNT, 2'b00};
  logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        deep_idle_mode = 1'b0, stop_mode = 1'b0, warmup_start = 1'b0;
  logic [31:0] prdata, rd, prev, wv;
  logic        pready, pslverr, er, runaway_interrupt, watchdog_out;
  logic        chip_reset_req, warmup_busy, warmup_done, irq;
  logic [7:0]  code;
  int          n_errors = 0, n_tests = 0, cyc = 0, seed = 2, n;

  rwwt_top dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .deep_idle_mode(deep_idle_mode), .stop_mode(stop_mode),
    .warmup_start(warmup_start), .runaway_interrupt(runaway_interrupt),
    .watchdog_out(watchdog_out), .chip_reset_req(chip_reset_req),
    .warmup_busy(warmup_busy), .warmup_done(warmup_done), .irq(irq));

  always #5 pclk = ~pclk;

  // whole run is about 82k cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 95000) begin
      n_errors++;
      give_verdict();
    end
  end

  task give_verdict;
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask

  task chk_rng(input string nm, input int e, input int g);
    n_tests++;
    if (g < e - 8 || g > e + 8) begin
      n_errors++;
      $display("wrong value %s exp %0d got %0d", nm, e, g);
    end
  endtask

  // request held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // 0: runaway interrupt, 1: warm-up done
  task wait_ev(input int which, output int k);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (!((which == 0 && runaway_interrupt === 1'b1) || (which == 1 && warmup_done === 1'b1))
               && k < 40000);
  endtask

  task warm(input int e);
    @(posedge pclk);
    warmup_start <= 1'b1;
    @(posedge pclk);
    warmup_start <= 1'b0;
    @(posedge pclk);
    chk("warm_busy_on", 32'h1, {31'h0, warmup_busy});
    wait_ev(1, n);
    chk_rng("warm_len", e, n);
    chk("warm_busy", 32'h0, {31'h0, warmup_busy});
  endtask

  function automatic int period(input logic [1:0] sel);
    return 1 << (rwwt_pkg::WD_EXP0 + 2 * sel);
  endfunction

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, A_MODE, 0);
    chk("mode_rst", 32'h80, rd);
    apb(0, A_CNT, 0);
    chk("cnt_on", 32'h1, {31'h0, rd[22]});
    apb(0, 12'hffc, 0);
    chk("unmapped", 32'h1, {31'h0, er});
    chk("unmapped_rd", 32'h0, rd);
    // overflow, status and interrupt
    apb(1, A_EN, 32'h1);
    apb(1, A_CMD, 32'h4e);
    wait_ev(0, n);
    chk_rng("period", period(2'b00), n);
    chk("wd_out", 32'h1, {31'h0, watchdog_out});
    apb(0, A_STAT, 0);
    chk("stat_ovf", 32'h1, {31'h0, rd[0]});
    chk("irq_on", 32'h1, {31'h0, irq});
    apb(1, A_EN, 32'h0);
    apb(0, A_STAT, 0);
    chk("irq_mask", 32'h0, {31'h0, irq});
    apb(1, A_EN, 32'h1);
    apb(1, A_CLR, 32'h1);
    apb(0, A_STAT, 0);
    chk("stat_clr", 32'h0, {31'h0, rd[0]});
    chk("irq_clr", 32'h0, {31'h0, irq});
    apb(1, A_CMD, 32'h4e);
    @(posedge pclk);
    chk("wd_out_clr", 32'h0, {31'h0, watchdog_out});
    // frozen in deep idle and in stop
    for (int m = 0; m < 2; m++) begin
      @(posedge pclk);
      deep_idle_mode <= (m == 0);
      stop_mode      <= (m == 1);
      apb(0, A_CNT, 0);
      prev = rd;
      apb(0, A_CNT, 0);
      chk("cnt_frozen", prev, rd);
      @(posedge pclk);
      deep_idle_mode <= 1'b0;
      stop_mode      <= 1'b0;
    end
    // clock enable low for ten edges holds the chain
    apb(0, A_CNT, 0);
    prev = rd;
    @(posedge pclk);
    ce <= 1'b0;
    repeat (10) @(posedge pclk);
    ce <= 1'b1;
    apb(0, A_CNT, 0);
    chk("ce_freeze", prev + 32'd5, rd);
    // other command codes leave counter and enable alone
    for (int i = 0; i < 4; i++) begin
      code = 8'($random(seed));
      if (code == rwwt_pkg::CODE_CLR || code == rwwt_pkg::CODE_DIS)
        code = code ^ 8'h01;
      apb(0, A_CNT, 0);
      prev = rd;
      apb(1, A_CMD, {24'h0, code});
      apb(0, A_CNT, 0);
      chk("cnt_runs", prev + 32'd8, rd);
      chk("cnt_en", 32'h1, {31'h0, rd[22]});
    end
    // mode fields read back; watchdog kept on
    wv = $random(seed);
    apb(1, A_MODE, wv | 32'h80);
    apb(0, A_MODE, 0);
    chk("mode_rw", (wv | 32'h80) & 32'hf2, rd);
    apb(1, A_MODE, 32'h80);
    // disable needs both steps, in order
    apb(1, A_CMD, 32'hb1);
    apb(0, A_CNT, 0);
    chk("dis_alone", 32'h1, {31'h0, rd[22]});
    apb(1, A_MODE, 32'h00);
    apb(0, A_CNT, 0);
    chk("off_alone", 32'h1, {31'h0, rd[22]});
    apb(1, A_CMD, 32'hb1);
    apb(0, A_CNT, 0);
    chk("disabled", 32'h0, {31'h0, rd[22]});
    apb(1, A_MODE, 32'h80);
    apb(0, A_CNT, 0);
    chk("reenabled", 32'h1, {31'h0, rd[22]});
    // quick warm-up refused while watchdog runs
    apb(1, A_QCK, 32'h1);
    warm(1 << rwwt_pkg::WARM_S);
    apb(1, A_MODE, 32'h00);
    apb(1, A_CMD, 32'hb1);
    warm(1 << rwwt_pkg::WARM_Q);
    apb(0, A_STAT, 0);
    chk("no_ovf", 32'h2, rd);
    // linked overflow resets chip and watchdog
    apb(1, A_QCK, 32'h0);
    apb(1, A_MODE, 32'h82);
    apb(1, A_CMD, 32'h4e);
    wait_ev(0, n);
    chk("chip_rst", 32'h1, {31'h0, chip_reset_req});
    apb(0, A_MODE, 0);
    chk("self_rst", 32'h80, rd);
    give_verdict();
  end
endmodule
`default_nettype wire
